//--- core/acc_pkg.sv
// Constants of the calibration and output control block.
package acc_pkg;
   // Register byte offsets.
   localparam logic [3:0] REG_CONFIG = 4'h0;
   localparam logic [3:0] REG_RANGE = 4'h4;
   localparam logic [3:0] REG_STATUS = 4'h8;
   // Configuration register field positions.
   localparam int CFG_DEMUX2 = 0;
   localparam int CFG_DDR = 1;
   localparam int CFG_EDGE = 2;
   localparam int CFG_SWING = 3;
   // Reset values.
   localparam logic [3:0] CONFIG_RESET = 4'h0;
   localparam logic [9:0] RANGE_RESET = 10'h2BC;
   // Ranges in mV peak to peak.
   localparam logic [9:0] RANGE_PIN_HIGH = 10'h366;
   localparam logic [9:0] RANGE_PIN_LOW = 10'h28A;
   localparam logic [9:0] RANGE_MIN = 10'h230;
   localparam logic [9:0] RANGE_MAX = 10'h348;
   // Counts in input clock cycles, except the start-up count, which is in system clock cycles.
   localparam logic [6:0] CAL_QUAL_CYCLES = 7'h50;
   localparam logic [15:0] CAL_RUN_CYCLES = 16'h0400;
   localparam logic [2:0] STARTUP_CYCLES = 3'h4;
   // History depth in input edges, and lane taps.
   localparam int HIST_DEPTH = 30;
   localparam int TAP_D = 26;
   localparam int TAP_C = 27;
   localparam int TAP_B = 28;
   localparam int TAP_A = 29;
   // Pin synchroniser bit positions.
   localparam int PIN_CLK = 0;
   localparam int PIN_CAL = 1;
   localparam int PIN_STBY = 2;
   localparam int PIN_FS = 3;
   localparam int PIN_EDGE = 4;
   localparam int PIN_FLOAT = 5;
   localparam int PIN_SWING = 6;
   localparam int PIN_DLY = 7;
   localparam int PIN_EXT = 8;
   localparam int PIN_COUNT = 9;
   // Calibration sequencer states.
   typedef enum logic [2:0] {
      CS_START,
      CS_DELAY,
      CS_RUN,
      CS_IDLE,
      CS_DOWN
   } acc_cal_state_t;
endpackage

//--- core/acc_top.sv
// Calibration sequencing and output lanes for an 8-bit converter.
//
// The implementer's own choices: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ps
// Operation
// - under range gives all zeros
// - over range gives all ones
// - overrange flag on either side
// - four-way demux, four lanes, quarter rate
// - two-way demux uses lanes c, d
// - calibrate at power-up and on command
// - no calibration while powered down
// - command is 80 low, 80 high
// - request high at power-up withholds calibration
// - power-up delay 2^25 or 2^31 cycles
// - standby at power-up halts delay
// - cal_in_progress high during calibration
// - sample on both input clock edges
// - latency 13 cycles c,d; 14 a,b
// - offset binary output
// - extended mode uses register settings
// - range pin picks 870 or 650 mV
// - extended range 560 to 840 mV
// - single or double rate, selectable edge
// - standby waits for calibration end
// - calibrate request ignored while down
// - single rate edge set by edge pin
// - floating edge pin selects double rate
module acc_top #(
   parameter logic [31:0] DELAY_SHORT = 32'h0200_0000, // Short delay.
   parameter logic [31:0] DELAY_LONG = 32'h8000_0000 // Long delay.
) (
   input logic mclk, // System clock.
   input logic reset, // Async reset.
   input logic conv_clk, // Input clock pin.
   input logic signed [9:0] input_level, // Input level.
   input logic calibrate_request, // Cal command.
   input logic standby_request, // Standby pin.
   input logic full_scale_select, // Range pin.
   input logic output_edge_select, // Edge pin.
   input logic output_edge_float, // Edge pin floats.
   input logic output_swing_select, // Swing pin.
   input logic cal_delay_select, // Delay pin.
   input logic ext_control, // Mode pin.
   input logic wb_cyc_i, // Bus cycle.
   input logic wb_stb_i, // Bus strobe.
   input logic wb_we_i, // Bus write.
   input logic [3:0] wb_adr_i, // Bus address.
   input logic [3:0] wb_sel_i, // Bus selects.
   input logic [31:0] wb_dat_i, // Write data.
   output logic [31:0] wb_dat_o, // Read data.
   output logic wb_ack_o, // Bus ack.
   output logic [7:0] lane_a, // Output lane a.
   output logic [7:0] lane_b, // Output lane b.
   output logic [7:0] lane_c, // Output lane c.
   output logic [7:0] lane_d, // Output lane d.
   output logic out_of_range_flag, // Overrange.
   output logic output_data_clock, // Data clock.
   output logic output_drive_n, // Drive enable.
   output logic cal_in_progress, // Calibrating.
   output logic [9:0] full_scale_mv, // Range in mV.
   output logic swing_high // Swing setting.
);

   // Synchroniser stages; a pin value counts once the last two agree.
   logic [acc_pkg::PIN_COUNT-1:0] pin_raw;
   logic [acc_pkg::PIN_COUNT-1:0] s1_r, s2_r, s3_r, pin_r;
   logic [acc_pkg::PIN_COUNT-1:0] s1_nxt, s2_nxt, s3_nxt, pin_nxt;
   assign pin_raw = {ext_control, cal_delay_select, output_swing_select, output_edge_float,
                     output_edge_select, full_scale_select, standby_request,
                     calibrate_request, conv_clk};

   // Each pin filters independently.
   genvar gi;
   generate
      for (gi = 0; gi < acc_pkg::PIN_COUNT; gi++) begin : g_pin
         always_comb begin
            s1_nxt[gi] = pin_raw[gi];
            s2_nxt[gi] = s1_r[gi];
            s3_nxt[gi] = s2_r[gi];
            pin_nxt[gi] = (s2_r[gi] == s3_r[gi]) ? s3_r[gi] : pin_r[gi];
         end
      end
   endgenerate

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
         pin_r <= '0;
      end else begin
         s1_r <= s1_nxt;
         s2_r <= s2_nxt;
         s3_r <= s3_nxt;
         pin_r <= pin_nxt;
      end
   end

   // Input clock edges found in the system clock domain.
   logic clk_prev_r, clk_prev_nxt, clk_rise, clk_fall;
   assign clk_prev_nxt = pin_r[acc_pkg::PIN_CLK];
   assign clk_rise = pin_r[acc_pkg::PIN_CLK] & ~clk_prev_r;
   assign clk_fall = ~pin_r[acc_pkg::PIN_CLK] & clk_prev_r;

   // Wishbone registers; settings reach the datapath only in extended mode.
   logic [3:0] config_r, config_nxt;
   logic [9:0] range_r, range_nxt;
   logic ack_r, ack_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic bus_req;
   logic ext_mode;
   acc_pkg::acc_cal_state_t state_r, state_nxt;
   assign bus_req = wb_cyc_i & wb_stb_i & ~ack_r;
   assign ext_mode = pin_r[acc_pkg::PIN_EXT];

   // Clamp a programmed range.
   function automatic logic [9:0] clamp_range(input logic [9:0] v);
      if (v < acc_pkg::RANGE_MIN) begin
         return acc_pkg::RANGE_MIN;
      end else if (v > acc_pkg::RANGE_MAX) begin
         return acc_pkg::RANGE_MAX;
      end
      return v;
   endfunction

   // Answers one cycle after the request; unmapped reads give zero.
   always_comb begin
      config_nxt = config_r;
      range_nxt = range_r;
      rdata_nxt = rdata_r;
      ack_nxt = bus_req;
      if (bus_req && wb_we_i && wb_sel_i[0]) begin
         case (wb_adr_i)
            acc_pkg::REG_CONFIG: config_nxt = wb_dat_i[3:0];
            acc_pkg::REG_RANGE: range_nxt = clamp_range({wb_sel_i[1] ? wb_dat_i[9:8] : range_r[9:8],
                                                           wb_dat_i[7:0]});
            default: config_nxt = config_r;
         endcase
      end
      if (bus_req) begin
         case (wb_adr_i)
            acc_pkg::REG_CONFIG: rdata_nxt = {28'h0000000, config_r};
            acc_pkg::REG_RANGE: rdata_nxt = {22'h000000, range_r};
            acc_pkg::REG_STATUS: rdata_nxt = {28'h0000000, ext_mode,
                                               state_r == acc_pkg::CS_DELAY,
                                               state_r == acc_pkg::CS_DOWN, cal_in_progress};
            default: rdata_nxt = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         config_r <= acc_pkg::CONFIG_RESET;
         range_r <= acc_pkg::RANGE_RESET;
         ack_r <= 1'b0;
         rdata_r <= 32'h0000_0000;
         clk_prev_r <= 1'b0;
      end else begin
         config_r <= config_nxt;
         range_r <= range_nxt;
         ack_r <= ack_nxt;
         rdata_r <= rdata_nxt;
         clk_prev_r <= clk_prev_nxt;
      end
   end
   assign wb_ack_o = ack_r;
   assign wb_dat_o = rdata_r;

   // Effective settings: pins in normal mode, registers in extended mode.
   logic ddr_mode, edge_rise, demux2;
   always_comb begin
      if (ext_mode) begin
         ddr_mode = config_r[acc_pkg::CFG_DDR];
         edge_rise = config_r[acc_pkg::CFG_EDGE];
         swing_high = config_r[acc_pkg::CFG_SWING];
         full_scale_mv = range_r;
      end else begin
         ddr_mode = pin_r[acc_pkg::PIN_FLOAT];
         edge_rise = pin_r[acc_pkg::PIN_EDGE];
         swing_high = pin_r[acc_pkg::PIN_SWING];
         full_scale_mv = pin_r[acc_pkg::PIN_FS] ? acc_pkg::RANGE_PIN_HIGH
                                                : acc_pkg::RANGE_PIN_LOW;
      end
      demux2 = ext_mode & config_r[acc_pkg::CFG_DEMUX2];
   end

   // Command qualifier: low phase, then high phase.
   logic [6:0] qual_cnt_r, qual_cnt_nxt;
   logic qual_low_ok_r, qual_low_ok_nxt;
   logic cal_cmd;
   logic cal_pin;
   assign cal_pin = pin_r[acc_pkg::PIN_CAL];
   always_comb begin
      qual_cnt_nxt = qual_cnt_r;
      qual_low_ok_nxt = qual_low_ok_r;
      cal_cmd = 1'b0;
      if (state_r == acc_pkg::CS_DOWN) begin
         qual_cnt_nxt = 7'h00;
         qual_low_ok_nxt = 1'b0;
      end else if (clk_rise) begin
         if (!qual_low_ok_r) begin
            if (cal_pin) begin
               qual_cnt_nxt = 7'h00;
            end else if (qual_cnt_r == acc_pkg::CAL_QUAL_CYCLES - 7'h01) begin
               qual_cnt_nxt = 7'h00;
               qual_low_ok_nxt = 1'b1;
            end else begin
               qual_cnt_nxt = qual_cnt_r + 7'h01;
            end
         end else if (!cal_pin) begin
            qual_cnt_nxt = 7'h00;
         end else if (qual_cnt_r == acc_pkg::CAL_QUAL_CYCLES - 7'h01) begin
            qual_cnt_nxt = 7'h00;
            qual_low_ok_nxt = 1'b0;
            cal_cmd = 1'b1;
         end else begin
            qual_cnt_nxt = qual_cnt_r + 7'h01;
         end
      end
   end

   // Calibration sequencer.
   logic [31:0] delay_cnt_r, delay_cnt_nxt;
   logic [15:0] run_cnt_r, run_cnt_nxt;
   logic [2:0] start_cnt_r, start_cnt_nxt;
   logic hold_r, hold_nxt;
   logic [31:0] delay_target;
   logic stby;
   assign stby = pin_r[acc_pkg::PIN_STBY];
   assign delay_target = pin_r[acc_pkg::PIN_DLY] ? DELAY_LONG : DELAY_SHORT;
   always_comb begin
      state_nxt = state_r;
      delay_cnt_nxt = delay_cnt_r;
      run_cnt_nxt = run_cnt_r;
      start_cnt_nxt = start_cnt_r;
      hold_nxt = hold_r;
      if (cal_cmd) begin
         hold_nxt = 1'b0;
      end
      case (state_r)
         acc_pkg::CS_START: begin
            // Let the filters settle before catching the request level.
            start_cnt_nxt = start_cnt_r + 3'h1;
            if (start_cnt_r == acc_pkg::STARTUP_CYCLES) begin
               hold_nxt = cal_pin;
               state_nxt = acc_pkg::CS_DELAY;
            end
         end
         acc_pkg::CS_DELAY: begin
            if (clk_rise && !stby && delay_cnt_r != delay_target) begin
               delay_cnt_nxt = delay_cnt_r + 32'h0000_0001;
            end
            if (delay_cnt_r == delay_target && !hold_r && !cal_cmd && !stby) begin
               state_nxt = acc_pkg::CS_RUN;
               run_cnt_nxt = 16'h0000;
            end
         end
         acc_pkg::CS_RUN: begin
            if (clk_rise) begin
               run_cnt_nxt = run_cnt_r + 16'h0001;
            end
            if (run_cnt_r == acc_pkg::CAL_RUN_CYCLES) begin
               state_nxt = stby ? acc_pkg::CS_DOWN : acc_pkg::CS_IDLE;
            end
         end
         acc_pkg::CS_IDLE: begin
            if (stby) begin
               state_nxt = acc_pkg::CS_DOWN;
            end else if (cal_cmd) begin
               state_nxt = acc_pkg::CS_RUN;
               run_cnt_nxt = 16'h0000;
            end
         end
         acc_pkg::CS_DOWN: begin
            if (!stby) begin
               state_nxt = acc_pkg::CS_IDLE;
            end
         end
         default: state_nxt = acc_pkg::CS_START;
      endcase
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         state_r <= acc_pkg::CS_START;
         delay_cnt_r <= 32'h0000_0000;
         run_cnt_r <= 16'h0000;
         start_cnt_r <= 3'h0;
         hold_r <= 1'b0;
         qual_cnt_r <= 7'h00;
         qual_low_ok_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         delay_cnt_r <= delay_cnt_nxt;
         run_cnt_r <= run_cnt_nxt;
         start_cnt_r <= start_cnt_nxt;
         hold_r <= hold_nxt;
         qual_cnt_r <= qual_cnt_nxt;
         qual_low_ok_r <= qual_low_ok_nxt;
      end
   end
   assign cal_in_progress = (state_r == acc_pkg::CS_RUN);

   // Offset-binary code plus an overrange bit.
   function automatic logic [8:0] quantise(input logic signed [9:0] v);
      if (v < -10'sd128) begin
         return 9'h100;
      end else if (v > 10'sd127) begin
         return 9'h1FF;
      end
      return {1'b0, v[7:0] ^ 8'h80};
   endfunction

   // One history entry per input edge, newest at index zero.
   logic [8:0] hist_r [acc_pkg::HIST_DEPTH];
   logic [8:0] hist_nxt [acc_pkg::HIST_DEPTH];
   generate
      for (gi = 0; gi < acc_pkg::HIST_DEPTH; gi++) begin : g_hist
         always_comb begin
            hist_nxt[gi] = hist_r[gi];
            if (clk_rise || clk_fall) begin
               hist_nxt[gi] = (gi == 0) ? quantise(input_level) : hist_r[(gi == 0) ? 0 : gi - 1];
            end
         end
         always_ff @(posedge mclk or posedge reset) begin
            if (reset) begin
               hist_r[gi] <= 9'h000;
            end else begin
               hist_r[gi] <= hist_nxt[gi];
            end
         end
      end
   endgenerate

   // Lanes load on falling input edges, every other one with four lanes.
   // The history is read before this edge shifts in, so taps sit one entry early.
   logic [7:0] la_r, lb_r, lc_r, ld_r, la_nxt, lb_nxt, lc_nxt, ld_nxt;
   logic or_r, or_nxt, phase_r, phase_nxt, output_data_clock_r, output_data_clock_nxt;
   always_comb begin
      la_nxt = la_r;
      lb_nxt = lb_r;
      lc_nxt = lc_r;
      ld_nxt = ld_r;
      or_nxt = or_r;
      phase_nxt = phase_r;
      output_data_clock_nxt = output_data_clock_r;
      if (clk_fall) begin
         phase_nxt = ~phase_r;
         if (demux2) begin
            // Two-way only works in double rate; else the lanes hold.
            if (ddr_mode) begin
               ld_nxt = hist_r[acc_pkg::TAP_D - 1][7:0];
               lc_nxt = hist_r[acc_pkg::TAP_C - 1][7:0];
               la_nxt = 8'h00;
               lb_nxt = 8'h00;
               or_nxt = hist_r[acc_pkg::TAP_D - 1][8] | hist_r[acc_pkg::TAP_C - 1][8];
               output_data_clock_nxt = ~output_data_clock_r;
            end
         end else if (phase_r) begin
            ld_nxt = hist_r[acc_pkg::TAP_D - 1][7:0];
            lc_nxt = hist_r[acc_pkg::TAP_C - 1][7:0];
            lb_nxt = hist_r[acc_pkg::TAP_B - 1][7:0];
            la_nxt = hist_r[acc_pkg::TAP_A - 1][7:0];
            or_nxt = hist_r[acc_pkg::TAP_D - 1][8] | hist_r[acc_pkg::TAP_C - 1][8]
                     | hist_r[acc_pkg::TAP_B - 1][8] | hist_r[acc_pkg::TAP_A - 1][8];
            // Double rate toggles per word; single rate marks the update edge.
            output_data_clock_nxt = ddr_mode ? ~output_data_clock_r : edge_rise;
         end else if (!ddr_mode) begin
            output_data_clock_nxt = ~edge_rise;
         end
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         la_r <= 8'h00;
         lb_r <= 8'h00;
         lc_r <= 8'h00;
         ld_r <= 8'h00;
         or_r <= 1'b0;
         phase_r <= 1'b0;
         output_data_clock_r <= 1'b0;
      end else begin
         la_r <= la_nxt;
         lb_r <= lb_nxt;
         lc_r <= lc_nxt;
         ld_r <= ld_nxt;
         or_r <= or_nxt;
         phase_r <= phase_nxt;
         output_data_clock_r <= output_data_clock_nxt;
      end
   end

   // Outputs float in power-down; the enable tells the pads.
   assign lane_a = la_r;
   assign lane_b = lb_r;
   assign lane_c = lc_r;
   assign lane_d = ld_r;
   assign out_of_range_flag = or_r;
   assign output_data_clock = output_data_clock_r;
   assign output_drive_n = (state_r == acc_pkg::CS_DOWN);

endmodule

//--- bench/acc_top_sva.sv
// Property checker for the calibration and output control block.
`timescale 1ns/1ps
module acc_top_sva (
   input logic mclk, // Clock.
   input logic reset, // Reset.
   input logic wb_cyc_i, // Cycle.
   input logic wb_stb_i, // Strobe.
   input logic wb_ack_o, // Ack.
   input logic [7:0] lane_a, // Lane a.
   input logic [7:0] lane_b, // Lane b.
   input logic [7:0] lane_c, // Lane c.
   input logic [7:0] lane_d, // Lane d.
   input logic out_of_range_flag, // Overrange.
   input logic output_data_clock, // Data clock.
   input logic output_drive_n, // Drive enable.
   input logic cal_in_progress, // Calibrating.
   input logic [9:0] full_scale_mv, // Range.
   input logic full_scale_select, // Range pin.
   input logic output_edge_select, // Edge pin.
   input logic output_edge_float, // Edge floats.
   input logic ext_control // Mode pin.
);
   default clocking @(posedge mclk); endclocking
   default disable iff (reset);
   logic [13:0] cal_cnt_r;
   logic [13:0] cal_cnt_nxt;
   // Run length; a narrow window catches a run that ends early or late.
   always_comb begin
      cal_cnt_nxt = cal_in_progress ? cal_cnt_r + 14'h1 : 14'h0;
   end
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) cal_cnt_r <= 14'h0;
      else cal_cnt_r <= cal_cnt_nxt;
   end
   property p_ack_answer;
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
   endproperty
   a_ack_answer: assert property (p_ack_answer) else $error("ack late");
   property p_ack_pulse;
      wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
   property p_fs_pin;
      (!ext_control && $stable(full_scale_select))[*6] |-> full_scale_mv ==
         (full_scale_select ? acc_pkg::RANGE_PIN_HIGH : acc_pkg::RANGE_PIN_LOW);
   endproperty
   a_fs_pin: assert property (p_fs_pin) else $error("pin range wrong");
   property p_fs_ext;
      (ext_control)[*6] |-> full_scale_mv >= acc_pkg::RANGE_MIN &&
         full_scale_mv <= acc_pkg::RANGE_MAX;
   endproperty
   a_fs_ext: assert property (p_fs_ext) else $error("range out of bounds");
   property p_range_flag;
      out_of_range_flag |-> lane_a inside {8'h00, 8'hFF} || lane_b inside {8'h00, 8'hFF} ||
         lane_c inside {8'h00, 8'hFF} || lane_d inside {8'h00, 8'hFF};
   endproperty
   a_range_flag: assert property (p_range_flag) else $error("flag without end code");
   property p_down_no_cal;
      output_drive_n |-> !cal_in_progress;
   endproperty
   a_down_no_cal: assert property (p_down_no_cal) else $error("cal while down");
   property p_cal_len;
      $fell(cal_in_progress) |-> cal_cnt_r inside {[14'h1FF4:14'h2008]};
   endproperty
   a_cal_len: assert property (p_cal_len) else $error("cal length wrong");
   property p_ddr_clock;
      (!ext_control && output_edge_float)[*8] ##0 $changed(lane_d) |->
         $changed(output_data_clock);
   endproperty
   a_ddr_clock: assert property (p_ddr_clock) else $error("ddr clock stuck");
   property p_sdr_edge;
      (!ext_control && !output_edge_float && $stable(output_edge_select))[*8] ##0
         $changed(lane_d) |-> output_data_clock == output_edge_select;
   endproperty
   a_sdr_edge: assert property (p_sdr_edge) else $error("sdr edge wrong");
endmodule
bind acc_top acc_top_sva i_acc_top_sva (.mclk, .reset, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
   .lane_a, .lane_b, .lane_c, .lane_d, .out_of_range_flag, .output_data_clock,
   .output_drive_n, .cal_in_progress, .full_scale_mv, .full_scale_select,
   .output_edge_select, .output_edge_float, .ext_control);

//--- bench/acc_rx_model.sv
// Receiver model that rebuilds the sample stream.
`timescale 1ns/1ps
module acc_rx_model (
   input logic mclk, // System clock.
   input logic reset, // Asynchronous reset.
   input logic watch, // Check enable.
   input logic two_way, // Lanes c, d only.
   input logic [7:0] lane_a, // Lane a.
   input logic [7:0] lane_b, // Lane b.
   input logic [7:0] lane_c, // Lane c.
   input logic [7:0] lane_d, // Lane d.
   input logic output_data_clock, // Forwarded data clock.
   output logic [15:0] n_words, // Word count.
   output logic order_err // Ramp broken.
);
   logic output_data_clock_q = 1'b0;
   logic have_prev;
   logic [7:0] prev;
   logic [7:0] w [4];
   // Each clock transition is an update; lanes go earliest first.
   always @(posedge mclk or posedge reset) begin
      if (reset || !watch) begin
         n_words = 16'h0;
         order_err = 1'b0;
         have_prev = 1'b0;
      end else if (output_data_clock !== output_data_clock_q) begin
         w = '{lane_a, lane_b, lane_c, lane_d};
         for (int i = two_way ? 2 : 0; i < 4; i++) begin
            if (have_prev && w[i] !== ((prev == 8'hE3) ? 8'h1C : prev + 8'h1)) order_err = 1'b1;
            prev = w[i];
            have_prev = 1'b1;
            n_words = n_words + 16'h1;
         end
      end
      output_data_clock_q = output_data_clock;
   end
endmodule

//--- bench/test_adc_calibration_output_control.sv
// Self-checking bench for the calibration and output control block.
`timescale 1ns/1ps
module test_adc_calibration_output_control;
   logic mclk = 1'b0, reset = 1'b1, conv_clk = 1'b0, conv_q = 1'b0;
   logic signed [9:0] input_level = 10'h000;
   logic calibrate_request = 1'b0, standby_request = 1'b1, full_scale_select = 1'b0;
   logic output_edge_select = 1'b0, output_edge_float = 1'b1, output_swing_select = 1'b0;
   logic cal_delay_select = 1'b0, ext_control = 1'b0;
   logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'hF;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
   logic wb_ack_o, out_of_range_flag, output_data_clock, output_drive_n;
   logic cal_in_progress, swing_high, order_err;
   logic ramp_on = 1'b1, watch = 1'b0, two_way = 1'b0;
   logic [7:0] lane_a, lane_b, lane_c, lane_d;
   logic [9:0] full_scale_mv;
   logic [15:0] n_words;
   logic signed [9:0] lv [4] = '{10'h338, 10'h0C8, 10'h000, 10'h380};
   logic [7:0] cd [4] = '{8'h00, 8'hFF, 8'h80, 8'h00};
   int errors = 0, n_compared = 0, cycles = 0, ramp = 0;
   acc_top #(.DELAY_SHORT(32'h10), .DELAY_LONG(32'h20)) i_acc_top (.mclk, .reset, .conv_clk,
      .input_level, .calibrate_request, .standby_request, .full_scale_select,
      .output_edge_select, .output_edge_float, .output_swing_select, .cal_delay_select,
      .ext_control, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
      .wb_ack_o, .lane_a, .lane_b, .lane_c, .lane_d, .out_of_range_flag, .output_data_clock,
      .output_drive_n, .cal_in_progress, .full_scale_mv, .swing_high);
   acc_rx_model i_acc_rx_model (.mclk, .reset, .watch, .two_way, .lane_a, .lane_b, .lane_c,
      .lane_d, .output_data_clock, .n_words, .order_err);
   // System clock, and an 80 ns link clock off the system edges.
   always #5 mclk = ~mclk;
   always #40 conv_clk = ~conv_clk;
   task automatic print_verdict();
      $display("Compared %0d, errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // Ramp steps per link edge; the counter cuts a hang.
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      conv_q <= conv_clk;
      if (ramp_on && conv_q != conv_clk) begin
         ramp <= (ramp == 199) ? 0 : ramp + 1;
         input_level <= 10'(ramp - 100);
      end
      if (cycles == 90000) begin
         errors = errors + 1;
         print_verdict();
      end
   end
   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask
   // Classic cycle, held until ack is sampled high at a rising edge.
   task automatic wb_xfer(input logic we, input logic [3:0] adr, input logic [31:0] dat);
      int n;
      n = 0;
      @(posedge mclk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_dat_i <= dat;
      do begin
         @(posedge mclk);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      if (n >= 50) errors++;
   endtask
   task automatic wait_cal(input logic lvl, input int lim);
      int n;
      n = 0;
      while (cal_in_progress !== lvl && n < lim) begin
         @(posedge mclk);
         n++;
      end
      check("cal_in_progress", 32'(lvl), 32'(cal_in_progress));
   endtask
   // Command pattern in link clock rises; request left high.
   task automatic cal_cmd(input int lo, input int hi);
      @(posedge mclk);
      calibrate_request <= 1'b0;
      repeat (lo) @(posedge conv_clk);
      @(posedge mclk);
      calibrate_request <= 1'b1;
      repeat (hi) @(posedge conv_clk);
      @(posedge mclk);
   endtask
   initial begin
      @(negedge mclk);
      check("lane_d", 32'h0, 32'(lane_d));
      check("fs_reset", 32'(acc_pkg::RANGE_PIN_LOW), 32'(full_scale_mv));
      @(posedge mclk);
      reset <= 1'b0;
      wb_xfer(1'b0, acc_pkg::REG_RANGE, 32'h0);
      check("range_reg", 32'(acc_pkg::RANGE_RESET), rd);
      wb_xfer(1'b0, 4'hC, 32'h0);
      check("unmapped", 32'h0, rd);
      repeat (400) @(posedge mclk);
      check("cal_held", 32'h0, 32'(cal_in_progress));
      standby_request <= 1'b0;
      repeat (100) @(posedge mclk);
      check("cal_early", 32'h0, 32'(cal_in_progress));
      wait_cal(1'b1, 100);
      repeat (2000) @(posedge mclk);
      standby_request <= 1'b1;
      repeat (100) @(posedge mclk);
      check("cal_kept", 32'h1, 32'(cal_in_progress));
      wait_cal(1'b0, 7000);
      repeat (10) @(posedge mclk);
      check("drive_n", 32'h1, 32'(output_drive_n));
      cal_cmd(80, 85);
      repeat (20) @(posedge mclk);
      check("cal_down", 32'h0, 32'(cal_in_progress));
      standby_request <= 1'b0;
      repeat (50) @(posedge mclk);
      check("cal_after_up", 32'h0, 32'(cal_in_progress));
      cal_cmd(79, 85);
      repeat (30) @(posedge mclk);
      check("cal_short_low", 32'h0, 32'(cal_in_progress));
      cal_cmd(80, 79);
      check("cal_short_high", 32'h0, 32'(cal_in_progress));
      cal_cmd(80, 80);
      wait_cal(1'b1, 40);
      wait_cal(1'b0, 8300);
      watch <= 1'b1;
      repeat (600) @(posedge mclk);
      check("order_err", 32'h0, 32'(order_err));
      check("words_seen", 32'h1, 32'(n_words > 16'h64));
      watch <= 1'b0;
      ramp_on <= 1'b0;
      for (int i = 0; i < 4; i++) begin
         input_level <= lv[i];
         repeat (300) @(posedge mclk);
         check("lane_a", 32'(cd[i]), 32'(lane_a));
         check("lane_d", 32'(cd[i]), 32'(lane_d));
         check("flag", 32'(i < 2), 32'(out_of_range_flag));
      end
      input_level <= 10'h000;
      repeat (96) @(posedge mclk);
      check("lane_d_old", 32'h0, 32'(lane_d));
      repeat (60) @(posedge mclk);
      check("lane_a_new", 32'h80, 32'(lane_a));
      full_scale_select <= 1'b1;
      output_swing_select <= 1'b1;
      repeat (10) @(posedge mclk);
      check("fs_high", 32'(acc_pkg::RANGE_PIN_HIGH), 32'(full_scale_mv));
      check("swing", 32'h1, 32'(swing_high));
      cal_cmd(80, 80);
      wait_cal(1'b1, 40);
      ramp_on <= 1'b1;
      output_edge_float <= 1'b0;
      output_edge_select <= 1'b1;
      repeat (400) @(posedge mclk);
      output_edge_select <= 1'b0;
      repeat (400) @(posedge mclk);
      // Mode pin moves only under reset.
      calibrate_request <= 1'b1;
      ext_control <= 1'b1;
      cal_delay_select <= 1'b1;
      reset <= 1'b1;
      repeat (2) @(posedge mclk);
      reset <= 1'b0;
      repeat (400) @(posedge mclk);
      check("cal_withheld", 32'h0, 32'(cal_in_progress));
      check("fs_ext", 32'(acc_pkg::RANGE_RESET), 32'(full_scale_mv));
      wb_xfer(1'b1, acc_pkg::REG_RANGE, 32'h384);
      wb_xfer(1'b0, acc_pkg::REG_RANGE, 32'h0);
      check("range_max", 32'(acc_pkg::RANGE_MAX), rd);
      wb_xfer(1'b1, acc_pkg::REG_RANGE, 32'h1F4);
      check("fs_min", 32'(acc_pkg::RANGE_MIN), 32'(full_scale_mv));
      wb_xfer(1'b1, acc_pkg::REG_CONFIG, 32'h3);
      two_way <= 1'b1;
      repeat (300) @(posedge mclk);
      watch <= 1'b1;
      repeat (400) @(posedge mclk);
      check("order_two", 32'h0, 32'(order_err));
      check("lane_b_idle", 32'h0, 32'({lane_a, lane_b}));
      wb_xfer(1'b0, acc_pkg::REG_STATUS, 32'h0);
      check("status_ext", 32'h1, 32'(rd[3]));
      cal_cmd(80, 80);
      wait_cal(1'b1, 300);
      print_verdict();
   end
endmodule
